// ---- design/gco_pkg.sv ----
// Purpose: Shared constants for the gain and offset correction stage
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes: Data words are 24-bit two's complement
`default_nettype none

package gco_pkg;

  // ==========================================================
  // Widths and channel count
  localparam int DW = 24;
  localparam int CHANS = 4;
  localparam int AW = 6;
  localparam int EXP_W = 5;

  // ==========================================================
  // Register byte offsets
  localparam logic [AW-1:0] GAIN_BASE = 6'h00;
  localparam logic [AW-1:0] OFFS_BASE = 6'h10;
  localparam logic [AW-1:0] CTRL_ADDR = 6'h20;
  localparam logic [AW-1:0] STAT_ADDR = 6'h24;

  // ==========================================================
  // Control field positions
  localparam int CTRL_GAIN_EN = 0;
  localparam int CTRL_OFFS_EN = 1;
  localparam int CTRL_CAL_EN = 2;
  localparam int CTRL_EXP_LSB = 8;

  // ==========================================================
  // Status field positions
  localparam int STAT_S1_FULL = 0;
  localparam int STAT_OUT_FULL = 1;
  localparam int STAT_CAL_RUN = 2;

  // ==========================================================
  // Values and reset values
  localparam logic [EXP_W-1:0] EXP_MAX = 5'h18;
  localparam logic [DW-1:0] FULL_SCALE = 24'h7fffff;
  localparam logic [DW-1:0] RST_GAIN = 24'h000000;
  localparam logic [DW-1:0] RST_OFFS = 24'h000000;
  localparam logic [2:0] RST_EN = 3'h0;
  localparam logic [EXP_W-1:0] RST_EXP = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// ---- design/gco_top.sv ----
// Purpose: Per-channel gain and offset correction with offset calibration
// Assumes: Samples arrive on a valid/ready stream from logic on aclk
// Notes: Two register stages; registers reached over AXI4-Lite
`default_nettype none
`timescale 1ns/1ns

// Overview of operation
// - Gain and offset words are signed 24-bit
// - Separate gain and offset word per channel
// - Gain scales sample by gain over full scale
// - Offset correction subtracts offset word from sample
// - Calibration enable bit plus 5-bit shift exponent
// - Calibration writes each new estimate into offset word, except in a cycle with a bus write to that word
// - Offset word keeps last estimate after calibration
// - Each function has its own enable bit
module gco_top (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [5:0] awaddr, // Write byte address
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte strobes
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  output logic [1:0] bresp, // Write response code
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  input wire logic [5:0] araddr, // Read byte address
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response code
  input wire logic in_valid, // Filtered sample valid
  output logic in_ready, // Stage can take a sample
  input wire logic [23:0] in_data, // Filtered sample
  input wire logic [1:0] in_chan, // Sample channel
  output logic out_valid, // Corrected sample valid
  input wire logic out_ready, // Output path can take a sample
  output logic [23:0] out_data, // Corrected sample
  output logic [1:0] out_chan // Corrected sample channel
);

  // ==========================================================
  // Register storage
  logic [23:0] gain_reg [4]; // Per-channel gain words
  logic [23:0] offs_reg [4]; // Per-channel offset words
  logic gain_en_reg; // Gain correction enable
  logic offs_en_reg; // Offset correction enable
  logic cal_en_reg; // Offset calibration enable
  logic [4:0] exp_reg; // Calibration shift exponent

  // ==========================================================
  // Bus handshake state
  logic bvalid_reg; // Write response pending
  logic [1:0] bresp_reg; // Write response code
  logic rvalid_reg; // Read data pending
  logic [31:0] rdata_reg; // Read data held
  logic [1:0] rresp_reg; // Read response code

  // ==========================================================
  // Pipeline state
  logic s1_valid_reg; // Stage one holds a sample
  logic [23:0] s1_data_reg; // Captured sample
  logic [1:0] s1_chan_reg; // Captured channel
  logic [23:0] s1_gain_reg; // Gain snapshot for this sample
  logic [23:0] s1_offs_reg; // Offset snapshot for this sample
  logic s1_gen_reg; // Gain enable snapshot
  logic s1_oen_reg; // Offset enable snapshot
  logic out_valid_reg; // Output stage holds a sample
  logic [23:0] out_data_reg; // Corrected sample
  logic [1:0] out_chan_reg; // Corrected channel

  // ==========================================================
  // Write decode
  wire aw_take = ce && awvalid && wvalid && !bvalid_reg;
  wire w_gain = (awaddr[5:4] == gco_pkg::GAIN_BASE[5:4]);
  wire w_offs = (awaddr[5:4] == gco_pkg::OFFS_BASE[5:4]);
  wire w_ctrl = (awaddr[5:2] == gco_pkg::CTRL_ADDR[5:2]);
  wire w_stat = (awaddr[5:2] == gco_pkg::STAT_ADDR[5:2]);
  wire w_map = w_gain || w_offs || w_ctrl || w_stat;
  wire [1:0] w_ch = awaddr[3:2];

  // ==========================================================
  // Read decode
  wire ar_take = ce && arvalid && !rvalid_reg;
  wire [1:0] r_ch = araddr[3:2];
  wire r_gain = (araddr[5:4] == gco_pkg::GAIN_BASE[5:4]);
  wire r_offs = (araddr[5:4] == gco_pkg::OFFS_BASE[5:4]);
  wire r_ctrl = (araddr[5:2] == gco_pkg::CTRL_ADDR[5:2]);
  wire r_stat = (araddr[5:2] == gco_pkg::STAT_ADDR[5:2]);
  wire r_map = r_gain || r_offs || r_ctrl || r_stat;

  // Control and status words as software sees them
  wire [31:0] ctrl_word = {19'h0, exp_reg, 5'h0, cal_en_reg,
    offs_en_reg, gain_en_reg};
  wire [31:0] stat_word = {29'h0, cal_en_reg, out_valid_reg,
    s1_valid_reg};

  // Sign-extend 24-bit words into the 32-bit bus lane
  wire [31:0] r_gain_w = {{8{gain_reg[r_ch][23]}}, gain_reg[r_ch]};
  wire [31:0] r_offs_w = {{8{offs_reg[r_ch][23]}}, offs_reg[r_ch]};
  wire [31:0] r_word = r_gain ? r_gain_w :
    r_offs ? r_offs_w :
    r_ctrl ? ctrl_word :
    r_stat ? stat_word : 32'h0;

  // ==========================================================
  // Stream handshakes
  wire out_adv = !out_valid_reg || out_ready;
  wire s1_adv = ce && s1_valid_reg && out_adv;
  wire in_fire = in_valid && in_ready;

  // ==========================================================
  // Calibration arithmetic on the raw input sample
  // Exponents above the top code are clamped so the shift stays sane
  wire [4:0] exp_eff = (exp_reg > gco_pkg::EXP_MAX) ?
    gco_pkg::EXP_MAX : exp_reg;
  wire signed [24:0] cal_err = $signed({in_data[23], in_data}) -
    $signed({offs_reg[in_chan][23], offs_reg[in_chan]});
  wire signed [24:0] cal_step = cal_err >>> exp_eff;
  wire signed [24:0] cal_sum = $signed({offs_reg[in_chan][23],
    offs_reg[in_chan]}) + cal_step;
  // Estimate moves toward the sample, so it always fits 24 bits
  wire [23:0] cal_val = cal_sum[23:0];
  wire cal_fire = in_fire && cal_en_reg;

  // ==========================================================
  // Correction arithmetic on the snapshot in stage one
  wire signed [24:0] s1_samp = $signed({s1_data_reg[23], s1_data_reg});
  wire signed [24:0] s1_off = $signed({s1_offs_reg[23], s1_offs_reg});
  wire signed [24:0] diff = s1_oen_reg ? (s1_samp - s1_off) : s1_samp;
  wire signed [48:0] prod = diff * $signed(s1_gain_reg);
  wire signed [48:0] fs_div = $signed(49'(gco_pkg::FULL_SCALE));
  // Exact divide by the constant; costs area but keeps unity gain exact
  wire signed [48:0] quot = prod / fs_div;
  wire signed [48:0] scaled = s1_gen_reg ? quot : 49'(diff);
  wire sat_ok = (&scaled[48:23]) || !(|scaled[48:23]);
  // Clip to the 24-bit range instead of wrapping
  wire [23:0] sat_val = sat_ok ? scaled[23:0] :
    (scaled[48] ? 24'h800000 : 24'h7fffff);

  // ==========================================================
  // Byte-lane merge of a write into a 24-bit word
  function automatic logic [23:0] wmerge(
    input logic [23:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [23:0] res;
    res = old;
    for (int b = 0; b < 3; b++)
    begin
      if (strb[b])
      begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================================
  // Per-channel gain and offset words
  for (genvar c = 0; c < gco_pkg::CHANS; c++)
  begin : g_chan
    wire w_g = aw_take && w_gain && (w_ch == c);
    wire w_o = aw_take && w_offs && (w_ch == c);
    wire cal_c = ce && cal_fire && (in_chan == c);

    // Gain word: any signed 24-bit value is accepted
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        gain_reg[c] <= gco_pkg::RST_GAIN;
      end
      else if (w_g)
      begin
        gain_reg[c] <= wmerge(gain_reg[c], wdata, wstrb);
      end
    end

    // Offset word: software write, else calibration result
    // Without calibration the word is never touched by hardware
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        offs_reg[c] <= gco_pkg::RST_OFFS;
      end
      else if (w_o)
      begin
        offs_reg[c] <= wmerge(offs_reg[c], wdata, wstrb);
      end
      else if (cal_c)
      begin
        offs_reg[c] <= cal_val;
      end
    end
  end

  // ==========================================================
  // Control register: three independent enables and exponent
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {cal_en_reg, offs_en_reg, gain_en_reg} <= gco_pkg::RST_EN;
      exp_reg <= gco_pkg::RST_EXP;
    end
    else if (aw_take && w_ctrl && wstrb[0])
    begin
      gain_en_reg <= wdata[gco_pkg::CTRL_GAIN_EN];
      offs_en_reg <= wdata[gco_pkg::CTRL_OFFS_EN];
      cal_en_reg <= wdata[gco_pkg::CTRL_CAL_EN];
    end
    if (aresetn && aw_take && w_ctrl && wstrb[1])
    begin
      exp_reg <= wdata[gco_pkg::CTRL_EXP_LSB +: gco_pkg::EXP_W];
    end
  end

  // ==========================================================
  // Write response channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= gco_pkg::RESP_OKAY;
    end
    else if (aw_take)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= w_map ? gco_pkg::RESP_OKAY : gco_pkg::RESP_SLVERR;
    end
    else if (ce && bready)
    begin
      bvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Read data channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= gco_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= r_word;
      rresp_reg <= r_map ? gco_pkg::RESP_OKAY : gco_pkg::RESP_SLVERR;
    end
    else if (ce && rready)
    begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Stage one: capture sample with the coefficients of this moment
  // Later register writes cannot reach a sample already captured
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_valid_reg <= 1'b0;
      s1_data_reg <= 24'h0;
      s1_chan_reg <= 2'h0;
      s1_gain_reg <= gco_pkg::RST_GAIN;
      s1_offs_reg <= gco_pkg::RST_OFFS;
      s1_gen_reg <= 1'b0;
      s1_oen_reg <= 1'b0;
    end
    else if (in_fire)
    begin
      s1_valid_reg <= 1'b1;
      s1_data_reg <= in_data;
      s1_chan_reg <= in_chan;
      s1_gain_reg <= gain_reg[in_chan];
      s1_offs_reg <= offs_reg[in_chan];
      s1_gen_reg <= gain_en_reg;
      s1_oen_reg <= offs_en_reg;
    end
    else if (s1_adv)
    begin
      s1_valid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Output stage: corrected sample held until taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_valid_reg <= 1'b0;
      out_data_reg <= 24'h0;
      out_chan_reg <= 2'h0;
    end
    else if (s1_adv)
    begin
      out_valid_reg <= 1'b1;
      out_data_reg <= sat_val;
      out_chan_reg <= s1_chan_reg;
    end
    else if (ce && out_ready)
    begin
      out_valid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Port drivers
  assign awready = aw_take;
  assign wready = aw_take;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = ar_take;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  // Stage one frees when its sample moves on, so one-per-cycle flow
  assign in_ready = ce && (!s1_valid_reg || out_adv);
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;
  assign out_chan = out_chan_reg;

endmodule

`default_nettype wire

// ---- tb/gco_sva.sv ----
// Purpose: Port checks for the correction stage
// Assumes: One clock domain, reset active low
// Notes: Bound onto every instance of the stage
`timescale 1ns/1ns
`default_nettype none
module gco_sva (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset
  input wire logic ce, // Enable
  input wire logic awvalid, // Wr addr valid
  input wire logic awready, // Wr taken
  input wire logic [5:0] awaddr, // Wr addr
  input wire logic bvalid, // Wr answer
  input wire logic bready, // Wr answer taken
  input wire logic [1:0] bresp, // Wr code
  input wire logic arvalid, // Rd addr valid
  input wire logic arready, // Rd taken
  input wire logic [5:0] araddr, // Rd addr
  input wire logic rvalid, // Rd answer
  input wire logic [31:0] rdata, // Rd data
  input wire logic [1:0] rresp, // Rd code
  input wire logic in_valid, // Sample valid
  input wire logic in_ready, // Sample taken
  input wire logic out_valid, // Result valid
  input wire logic out_ready, // Result taken
  input wire logic [23:0] out_data // Result
);
  // ==========================================
  // Handshake timing; reset quiets every check
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_wr_answer: assert property (awvalid && awready && awaddr <= 6'h24
    |=> bvalid && bresp == 2'h0) else $error("write not answered");
  chk_rd_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
  chk_bad_read: assert property (arvalid && arready && araddr > 6'h24
    |=> rresp == 2'h2 && rdata == 32'h0) else $error("unmapped read wrong");
  chk_b_stands: assert property (bvalid && !(bready && ce) |=> bvalid)
    else $error("write answer dropped");
  chk_rd_busy: assert property (rvalid |-> !arready)
    else $error("read taken while busy");
  chk_out_stands: assert property (out_valid && !(out_ready && ce)
    |=> out_valid && $stable(out_data)) else $error("result changed");
  // A drained output stage must not delay the next result
  chk_sample_lat: assert property (in_valid && in_ready && out_ready ##1 out_ready && ce
    |=> out_valid) else $error("result late");
  chk_ce_freeze: assert property (!ce |-> !in_ready && !awready && !arready)
    else $error("stage moved while frozen");
endmodule
bind gco_top gco_sva u_sva (.*);
`default_nettype wire

// ---- tb/gco_far.sv ----
// Purpose: Filter-side source and output-side sink
// Assumes: Stream handshakes on rising edges
// Notes: A released sample line shows the inverse value
`timescale 1ns/1ns
`default_nettype none
module gco_far (
  input wire logic aclk, // Clock
  input wire logic hold, // Stall the sink
  input wire logic in_ready, // Sample taken
  input wire logic out_valid, // Result valid
  input wire logic [23:0] out_data, // Result
  input wire logic [1:0] out_chan, // Result channel
  output logic in_valid, // Sample valid
  output logic [23:0] in_data, // Sample
  output logic [1:0] in_chan, // Sample channel
  output logic out_ready // Sink free
);
  // ==========================================
  // Sink follows the stall request one cycle late
  initial
  begin
    in_valid = 1'b0;
    in_data = 24'h000000;
    in_chan = 2'h0;
    out_ready = 1'b0;
  end
  always @(posedge aclk)
  begin
    out_ready <= !hold;
  end
  // Offer one sample and hold it until taken
  task automatic send(input logic [1:0] c, input logic [23:0] d, output bit ok);
    ok = 1'b0;
    @(posedge aclk);
    in_valid <= 1'b1;
    in_data <= d;
    in_chan <= c;
    for (int n = 0; n < 40 && !ok; n++)
    begin
      @(posedge aclk);
      ok = in_ready;
    end
    in_valid <= 1'b0;
    in_data <= ~d; // Stale data must never pass as valid
  endtask
  // Take one result when both handshake sides agree
  task automatic recv(output logic [23:0] d, output logic [1:0] c, output bit ok);
    ok = 1'b0;
    for (int n = 0; n < 40 && !ok; n++)
    begin
      @(posedge aclk);
      ok = out_valid && out_ready;
      d = out_data;
      c = out_chan;
    end
  endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the correction stage
// Assumes: Bus answers within a few cycles
// Notes: Expected samples come from a bench-side model
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, hold, awready;
  logic wready, bvalid, arready, rvalid, in_ready, in_valid, out_valid, out_ready;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, in_chan, out_chan;
  logic [23:0] in_data, out_data;
  int failures, num_checks;
  bit ok;
  gco_top u_dut (.*);
  gco_far u_far (.*);
  // ==========================================
  // Clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic complete_run();
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // A used-up wait counts and ends the run
  task automatic to(input bit k);
    if (!k)
    begin
      failures++;
      complete_run();
    end
  endtask
  // ==========================================
  // Bus cycles; bready late so the answer must stand
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] er);
    ok = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    for (int n = 0; n < 40 && !ok; n++)
    begin
      @(posedge aclk);
      ok = awready && wready;
    end
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    to(ok);
    @(posedge aclk);
    bready <= 1'b1;
    ok = 1'b0;
    for (int n = 0; n < 40 && !ok; n++)
    begin
      @(posedge aclk);
      ok = bvalid;
    end
    bready <= 1'b0;
    to(ok);
    cmp(bresp, er);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    ok = 1'b0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !ok; n++)
    begin
      @(posedge aclk);
      ok = arready;
    end
    arvalid <= 1'b0;
    to(ok);
    ok = 1'b0;
    for (int n = 0; n < 40 && !ok; n++)
    begin
      @(posedge aclk);
      ok = rvalid;
    end
    rready <= 1'b0;
    to(ok);
    cmp(rdata, ed);
    cmp(rresp, er);
  endtask
  // ==========================================
  // Sample model: offset first, then gain, then clamp
  function automatic logic [23:0] corr(input logic [23:0] s, o, g, input bit ge, oe);
    logic signed [49:0] v;
    v = $signed(s);
    if (oe) v = v - $signed(o);
    if (ge) v = v * $signed(g) / 50'sh7fffff;
    if (v > 50'sh7fffff) v = 50'sh7fffff;
    if (v < -50'sh800000) v = -50'sh800000;
    return v[23:0];
  endfunction
  task automatic get(input logic [1:0] c, input logic [23:0] e);
    logic [23:0] d;
    logic [1:0] oc;
    u_far.recv(d, oc, ok);
    to(ok);
    cmp(d, e);
    cmp(oc, c);
  endtask
  task automatic samp(input logic [1:0] c, input logic [23:0] s, o, g, input bit ge, oe);
    u_far.send(c, s, ok);
    to(ok);
    get(c, corr(s, o, g, ge, oe));
  endtask
  function automatic logic [23:0] wv(input int i);
    return i[0] ? 24'h800000 + 24'(i) : 24'h7ffff8 + 24'(i);
  endfunction
  // Words clear at reset; unmapped places refuse
  task automatic t_reset();
    for (int i = 0; i < 8; i++)
      rd(6'(4 * i), 32'h0, 2'h0);
    rd(6'h28, 32'h0, 2'h2);
    wr(6'h3c, 32'h1, 4'hf, 2'h2);
  endtask
  // Extreme values, read back only after all writes
  task automatic t_words();
    logic [23:0] v;
    for (int i = 0; i < 8; i++)
      wr(6'(4 * i), {8'hff, wv(i)}, 4'hf, 2'h0);
    for (int i = 0; i < 8; i++)
    begin
      v = wv(i);
      rd(6'(4 * i), {{8{v[23]}}, v}, 2'h0);
    end
  endtask
  // Frozen, then stalled output with all corrections off
  task automatic t_pass();
    ce <= 1'b0;
    repeat (3) @(posedge aclk);
    ce <= 1'b1;
    hold <= 1'b1;
    u_far.send(2'h2, 24'h123456, ok);
    to(ok);
    repeat (4) @(posedge aclk);
    // Status: output stage full, stage one empty, calibration off
    rd(6'h24, 32'h2, 2'h0);
    hold <= 1'b0;
    get(2'h2, 24'h123456);
  endtask
  task automatic t_corr();
    wr(6'h14, 32'h100, 4'h7, 2'h0);
    wr(6'h18, 32'hffff00, 4'h7, 2'h0);
    wr(6'h20, 32'h2, 4'h1, 2'h0);
    samp(2'h1, 24'h000300, 24'h100, 24'h0, 1'b0, 1'b1);
    samp(2'h1, 24'h800000, 24'h100, 24'h0, 1'b0, 1'b1);
    samp(2'h2, 24'h7fffff, 24'hffff00, 24'h0, 1'b0, 1'b1);
    wr(6'h0c, 32'h400000, 4'h7, 2'h0);
    wr(6'h1c, 32'h100, 4'h7, 2'h0);
    wr(6'h20, 32'h1, 4'h1, 2'h0);
    samp(2'h3, 24'h7fffff, 24'h100, 24'h400000, 1'b1, 1'b0);
    samp(2'h3, 24'hffff00, 24'h100, 24'h400000, 1'b1, 1'b0);
    samp(2'h1, 24'h800000, 24'h100, 24'h800001, 1'b1, 1'b0);
    wr(6'h20, 32'h3, 4'h1, 2'h0);
    samp(2'h3, 24'h800000, 24'h100, 24'h400000, 1'b1, 1'b1);
  endtask
  // Writes land while one sample waits at the output and one in stage one;
  // both keep the old words, the next sample sees the new ones
  task automatic t_snap();
    hold <= 1'b1;
    u_far.send(2'h3, 24'h000500, ok);
    to(ok);
    u_far.send(2'h3, 24'h000700, ok);
    to(ok);
    wr(6'h1c, 32'h200, 4'h7, 2'h0);
    wr(6'h0c, 32'h7fffff, 4'h7, 2'h0);
    hold <= 1'b0;
    get(2'h3, corr(24'h000500, 24'h100, 24'h400000, 1'b1, 1'b1));
    get(2'h3, corr(24'h000700, 24'h100, 24'h400000, 1'b1, 1'b1));
    samp(2'h3, 24'h000500, 24'h200, 24'h7fffff, 1'b1, 1'b1);
  endtask
  // Calibrate channel 3 and watch its offset word
  task automatic cal(input logic [31:0] c, input logic [23:0] s, input logic [31:0] e);
    wr(6'h20, c, 4'h3, 2'h0);
    samp(2'h3, s, 24'h0, 24'h0, 1'b0, 1'b0);
    rd(6'h1c, e, 2'h0);
  endtask
  task automatic t_cal();
    wr(6'h1c, 32'h0, 4'h7, 2'h0);
    cal(32'h204, 24'h000400, 32'h100);
    cal(32'h204, 24'hfffc00, 32'hffffffc0);
    cal(32'h1804, 24'hffff00, 32'hffffffbf);
    cal(32'h1f04, 24'hffff00, 32'hffffffbe);
    cal(32'h004, 24'h000123, 32'h123);
    cal(32'h000, 24'h7fffff, 32'h123);
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    failures = 0;
    num_checks = 0;
    aresetn = 1'b0;
    ce = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, hold} = 6'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_words();
    t_pass();
    t_corr();
    t_snap();
    t_cal();
    complete_run();
  end
endmodule
`default_nettype wire
